// *** include/video_rx_pkg.sv ***
package video_rx_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 20;   // sys_clk_i at 50 MHz
  localparam int SYNC_LATENCY  = 3;    // Pin to edge-detect delay, in sys_clk cycles
  localparam int SETTLE_LO_NS  = 565;  // Settle ceiling, 80 to 94 MHz lane clock
  localparam int SETTLE_HI_NS  = 465;  // Settle ceiling, 95 to 235 MHz lane clock
  // Longest times round down; the synchroniser delay is taken off the budget
  localparam logic [4:0] SETTLE_LO_CYC = 5'(SETTLE_LO_NS / CLK_PERIOD_NS - SYNC_LATENCY);
  localparam logic [4:0] SETTLE_HI_CYC = 5'(SETTLE_HI_NS / CLK_PERIOD_NS - SYNC_LATENCY);

  // ==========================================================================
  // Widths and depths
  // ==========================================================================
  localparam int BUS_W      = 24;  // Full pixel data bus
  localparam int SAMPLE_W   = 8;   // Low byte carries the video samples
  localparam int LANES      = 4;   // Serial input data lanes
  localparam int PTR_W      = 3;   // Crossing pointer, one wrap bit
  localparam int CROSS_DEPTH = 4;  // Words held by the domain crossing

  // ==========================================================================
  // Embedded timing reference codes
  // ==========================================================================
  localparam logic [7:0] TRS_PREAMBLE  = 8'hff;
  localparam logic [7:0] TRS_ZERO      = 8'h00;
  localparam int         XY_FIXED_BIT  = 7;  // Always one in a valid status word
  localparam int         XY_FIELD_BIT  = 6;
  localparam int         XY_VBLANK_BIT = 5;
  localparam int         XY_EAV_BIT    = 4;  // One for end of video, zero for start

  // Byte slots of the interleaved Cb Y Cr Y sequence
  localparam logic [1:0] PH_CB = 2'h0;
  localparam logic [1:0] PH_Y0 = 2'h1;
  localparam logic [1:0] PH_CR = 2'h2;
  localparam logic [1:0] PH_Y1 = 2'h3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    S_SCAN = 2'b00,
    S_Z1   = 2'b01,
    S_Z2   = 2'b10,
    S_XY   = 2'b11
  } scan_state_t;

  typedef struct packed {
    logic       field;
    logic       line_start;
    logic [7:0] cb;
    logic [7:0] y0;
    logic [7:0] cr;
    logic [7:0] y1;
  } pixel_pair_t;

  typedef struct packed {
    logic                              rst_m;
    logic                              rst_s;
    scan_state_t                       state;
    logic [7:0]                        byte_q;
    logic                              field;
    logic                              vblank;
    logic                              active;
    logic                              first;
    logic [1:0]                        phase;
    logic [7:0]                        cb;
    logic [7:0]                        y0;
    logic [7:0]                        cr;
    logic [PTR_W-1:0]                  wptr_bin;
    logic [PTR_W-1:0]                  wptr_gray;
    logic [PTR_W-1:0]                  rgray_m;
    logic [PTR_W-1:0]                  rgray_s;
    logic                              ovf;
    pixel_pair_t [CROSS_DEPTH-1:0]     mem;
  } link_state_t;

  typedef struct packed {
    logic [PTR_W-1:0] wgray_m;
    logic [PTR_W-1:0] wgray_s;
    logic [PTR_W-1:0] rptr_bin;
    logic [PTR_W-1:0] rptr_gray;
    logic             ovf_m;
    logic             ovf_s;
    pixel_pair_t      pair;
    logic             pair_vld;
  } sys_state_t;

endpackage

// *** hw/dsi_lane_settle.sv ***
module dsi_lane_settle (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic low_band_i,
  input  wire logic hs_entry_i,
  output logic      ready_o
);

  typedef struct packed {
    logic       s_m;
    logic       s_s;
    logic       s_p;
    logic [4:0] cnt;
    logic       ready;
  } lane_state_t;

  lane_state_t q;
  lane_state_t n;

  // ==========================================================================
  // Settle window
  // ==========================================================================
  // Entry is synchronised first; the edge detector compares the second stage with the third
  always_comb begin
    n     = q;
    n.s_m = hs_entry_i;
    n.s_s = q.s_m;
    n.s_p = q.s_s;
    if (!enable_i || !q.s_s) begin
      n.cnt   = 5'h00;      // Lane unused or back in low power
      n.ready = 1'b0;
    end else if (!q.s_p) begin
      // Lane transitions are ignored while the window runs
      n.cnt   = low_band_i ? video_rx_pkg::SETTLE_LO_CYC : video_rx_pkg::SETTLE_HI_CYC;
      n.ready = 1'b0;
    end else if (q.cnt != 5'h00) begin
      n.cnt = q.cnt - 5'h01;
      if (q.cnt == 5'h01) begin
        n.ready = 1'b1;
      end
    end
    if (rst_i) begin
      n = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    q <= n;
  end

  assign ready_o = q.ready;

  // ==========================================================================
  // Checks
  // ==========================================================================
  localparam int LO_WAIT = int'(video_rx_pkg::SETTLE_LO_CYC);
  localparam int HI_WAIT = int'(video_rx_pkg::SETTLE_HI_CYC);

  // Cycles since the entry was seen, counted apart from the window counter.
  // It stays at zero for a lane that was high before it was enabled, and it
  // restarts on every new entry, so an aborted entry cannot fire the checks.
  // Limitation: the band is assumed steady while a window runs.
  logic [5:0] win_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !enable_i || !q.s_s) begin
      win_q <= 6'h00;
    end else if (!q.s_p) begin
      win_q <= 6'h01;
    end else if (win_q != 6'h00 && win_q != 6'h3f) begin
      win_q <= win_q + 6'h01;
    end
  end

  property p_settle_lo;
    @(posedge sys_clk_i) disable iff (rst_i)
      (enable_i && low_band_i && q.s_s && q.s_p) |-> (ready_o == (win_q > 6'(LO_WAIT)));
  endproperty
  a_settle_lo: assert property (p_settle_lo)
    else $error("low band settle window length wrong");

  property p_settle_hi;
    @(posedge sys_clk_i) disable iff (rst_i)
      (enable_i && !low_band_i && q.s_s && q.s_p) |-> (ready_o == (win_q > 6'(HI_WAIT)));
  endproperty
  a_settle_hi: assert property (p_settle_hi)
    else $error("high band settle window length wrong");

  property p_lane_off;
    @(posedge sys_clk_i) disable iff (rst_i)
      !enable_i |=> !ready_o;
  endproperty
  a_lane_off: assert property (p_lane_off)
    else $error("unselected lane reported ready");

endmodule

// *** hw/video_input_receiver.sv ***
// Functional notes
// - Parallel input port receives the standard digital video interface stream.
// - 8-bit 4:2:2 YCbCr words on the low byte, sampled on pixel clock edge.
// - Bus bits 7..0 carry sample bits 7..0; bits 23..8 are ignored.
// - Serial input runs one to four selectable lanes, 160-470 Mbps each.
// - Receiver ignores lane transitions for settle window, up to 565/465 ns.
module video_input_receiver (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          pixel_clk_i,
  input  wire logic [video_rx_pkg::BUS_W-1:0] pixel_data_bus_i,
  input  wire logic [1:0]                    dsi_lane_count_i,
  input  wire logic                          dsi_low_band_i,
  input  wire logic [video_rx_pkg::LANES-1:0] dsi_hs_entry_i,
  output video_rx_pkg::pixel_pair_t          pair_o,
  output logic                               pair_valid_o,
  output logic                               overflow_o,
  output logic [video_rx_pkg::LANES-1:0]     dsi_lane_ready_o
);

  video_rx_pkg::link_state_t lq;
  video_rx_pkg::link_state_t ln;
  video_rx_pkg::sys_state_t  sq;
  video_rx_pkg::sys_state_t  sn;

  logic                                 wr_en;
  logic                                 full;
  video_rx_pkg::pixel_pair_t            wr_pair;
  logic [video_rx_pkg::PTR_W-1:0]       wptr_inc;
  logic                                 empty;
  video_rx_pkg::pixel_pair_t            rd_word;
  logic [video_rx_pkg::PTR_W-1:0]       rptr_inc;
  logic [video_rx_pkg::LANES-1:0]       lane_en;

  // ==========================================================================
  // Pixel clock domain: capture, code search and pair assembly
  // ==========================================================================
  // The reset reaches this domain through two flops; a stopped pixel clock
  // simply delays it, which is harmless because nothing moves meanwhile
  always_comb begin
    ln       = lq;
    ln.rst_m = rst_i;
    ln.rst_s = lq.rst_m;
    // Only the low byte is sampled; the upper sixteen bits are never read
    ln.byte_q = pixel_data_bus_i[video_rx_pkg::SAMPLE_W-1:0];
    // Read pointer comes across in gray code
    ln.rgray_m = sq.rptr_gray;
    ln.rgray_s = lq.rgray_m;

    wr_en              = 1'b0;
    wr_pair.field      = lq.field;
    wr_pair.line_start = lq.first;
    wr_pair.cb         = lq.cb;
    wr_pair.y0         = lq.y0;
    wr_pair.cr         = lq.cr;
    wr_pair.y1         = lq.byte_q;

    // Reference code search: preamble, two zeros, then the status word
    case (lq.state)
      video_rx_pkg::S_SCAN: begin
        if (lq.byte_q == video_rx_pkg::TRS_PREAMBLE) begin
          ln.state = video_rx_pkg::S_Z1;
        end
      end
      video_rx_pkg::S_Z1: begin
        if (lq.byte_q == video_rx_pkg::TRS_ZERO) begin
          ln.state = video_rx_pkg::S_Z2;
        end else begin
          ln.state = video_rx_pkg::S_SCAN;
        end
      end
      video_rx_pkg::S_Z2: begin
        if (lq.byte_q == video_rx_pkg::TRS_ZERO) begin
          ln.state = video_rx_pkg::S_XY;
        end else begin
          ln.state = video_rx_pkg::S_SCAN;
        end
      end
      video_rx_pkg::S_XY: begin
        ln.state = video_rx_pkg::S_SCAN;
        // A status word without its fixed bit is corrupt and leaves timing alone
        if (lq.byte_q[video_rx_pkg::XY_FIXED_BIT]) begin
          ln.field  = lq.byte_q[video_rx_pkg::XY_FIELD_BIT];
          ln.vblank = lq.byte_q[video_rx_pkg::XY_VBLANK_BIT];
          ln.active = !lq.byte_q[video_rx_pkg::XY_EAV_BIT]
                    && !lq.byte_q[video_rx_pkg::XY_VBLANK_BIT];
          ln.phase  = video_rx_pkg::PH_CB;
          ln.first  = 1'b1;
        end
      end
      default: begin
        ln.state = video_rx_pkg::S_SCAN;
      end
    endcase

    // Active bytes arrive Cb Y Cr Y; a preamble ends the line at once
    if (lq.active) begin
      if (lq.byte_q == video_rx_pkg::TRS_PREAMBLE) begin
        ln.active = 1'b0;
      end else begin
        ln.phase = lq.phase + 2'h1;
        case (lq.phase)
          video_rx_pkg::PH_CB: begin
            ln.cb = lq.byte_q;
          end
          video_rx_pkg::PH_Y0: begin
            ln.y0 = lq.byte_q;
          end
          video_rx_pkg::PH_CR: begin
            ln.cr = lq.byte_q;
          end
          default: begin
            wr_en    = 1'b1;
            ln.first = 1'b0;
          end
        endcase
      end
    end

    // Write side of the crossing; a full crossing drops the pair
    full     = lq.wptr_gray == {~lq.rgray_s[video_rx_pkg::PTR_W-1:video_rx_pkg::PTR_W-2],
                                lq.rgray_s[0]};
    wptr_inc = lq.wptr_bin + 3'h1;
    if (wr_en) begin
      if (full) begin
        ln.ovf = 1'b1;
      end else begin
        ln.mem[lq.wptr_bin[video_rx_pkg::PTR_W-2:0]] = wr_pair;
        ln.wptr_bin  = wptr_inc;
        ln.wptr_gray = wptr_inc ^ (wptr_inc >> 1);
      end
    end

    if (lq.rst_s) begin
      ln       = '0;
      ln.rst_m = rst_i;
      ln.rst_s = lq.rst_m;
    end
  end

  always_ff @(posedge pixel_clk_i) begin
    lq <= ln;
  end

  // ==========================================================================
  // System clock domain: drain the crossing
  // ==========================================================================
  // The word is read one sync delay after its pointer moved, so it is stable
  always_comb begin
    sn          = sq;
    sn.wgray_m  = lq.wptr_gray;
    sn.wgray_s  = sq.wgray_m;
    sn.ovf_m    = lq.ovf;
    sn.ovf_s    = sq.ovf_m;
    sn.pair_vld = 1'b0;
    empty       = sq.rptr_gray == sq.wgray_s;
    rd_word     = lq.mem[sq.rptr_bin[video_rx_pkg::PTR_W-2:0]];
    rptr_inc    = sq.rptr_bin + 3'h1;
    if (!empty) begin
      sn.pair      = rd_word;
      sn.pair_vld  = 1'b1;
      sn.rptr_bin  = rptr_inc;
      sn.rptr_gray = rptr_inc ^ (rptr_inc >> 1);
    end
    if (rst_i) begin
      sn = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    sq <= sn;
  end

  assign pair_o       = sq.pair;
  assign pair_valid_o = sq.pair_vld;
  assign overflow_o   = sq.ovf_s;

  // ==========================================================================
  // Serial lane front ends
  // ==========================================================================
  // Lane count code 0 selects one lane, code 3 all four
  always_comb begin
    for (int i = 0; i < video_rx_pkg::LANES; i++) begin
      lane_en[i] = 2'(i) <= dsi_lane_count_i;
    end
  end

  for (genvar g = 0; g < video_rx_pkg::LANES; g++) begin : g_lane
    dsi_lane_settle u_settle (
      .sys_clk_i  (sys_clk_i),
      .rst_i      (rst_i),
      .enable_i   (lane_en[g]),
      .low_band_i (dsi_low_band_i),
      .hs_entry_i (dsi_hs_entry_i[g]),
      .ready_o    (dsi_lane_ready_o[g])
    );
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_low_byte;
    @(posedge pixel_clk_i) disable iff (lq.rst_s)
      !lq.rst_s |=> lq.byte_q == $past(pixel_data_bus_i[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("low byte not sampled on pixel clock edge");

  property p_upper_ignored;
    @(posedge pixel_clk_i) disable iff (lq.rst_s)
      ($changed(pixel_data_bus_i[23:8]) && $stable(pixel_data_bus_i[7:0]))
        |=> $stable(lq.byte_q);
  endproperty
  a_upper_ignored: assert property (p_upper_ignored)
    else $error("upper bus bits leaked into the sample");

  property p_sav_opens;
    @(posedge pixel_clk_i) disable iff (lq.rst_s)
      (lq.state == video_rx_pkg::S_XY && lq.byte_q[7] && !lq.byte_q[5] && !lq.byte_q[4])
        |=> lq.active && lq.phase == video_rx_pkg::PH_CB && lq.first;
  endproperty
  a_sav_opens: assert property (p_sav_opens)
    else $error("start code did not open the active line");

  property p_eav_closes;
    @(posedge pixel_clk_i) disable iff (lq.rst_s)
      (lq.state == video_rx_pkg::S_XY && lq.byte_q[7] && lq.byte_q[4])
        |=> !lq.active ##1 !wr_en;
  endproperty
  a_eav_closes: assert property (p_eav_closes)
    else $error("end code left the line active");

  property p_pair_order;
    @(posedge pixel_clk_i) disable iff (lq.rst_s)
      wr_en |-> wr_pair.y1 == lq.byte_q
             && wr_pair.cr == $past(lq.byte_q, 1)
             && wr_pair.y0 == $past(lq.byte_q, 2)
             && wr_pair.cb == $past(lq.byte_q, 3);
  endproperty
  a_pair_order: assert property (p_pair_order)
    else $error("pixel pair bytes out of order");

  property p_deliver;
    @(posedge sys_clk_i) disable iff (rst_i)
      !empty |=> pair_valid_o && pair_o == $past(rd_word);
  endproperty
  a_deliver: assert property (p_deliver)
    else $error("queued pair not delivered next cycle");

endmodule

// *** verif/video_source_model.sv ***
// ============================================================================
// Host video source: streams queued bytes, blanking filler otherwise
// ============================================================================
module video_source_model (
  input  wire logic        pixel_clk_i,
  output logic      [23:0] pixel_data_bus_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] tx_q[$];
  logic       fill_q = 1'b0;

  initial pixel_data_bus_o = 24'h000080;

  // One byte per active edge; upper bits are noise the receiver must drop
  always @(posedge pixel_clk_i) begin
    if (tx_q.size() > 0) begin
      pixel_data_bus_o <= {16'($urandom), tx_q.pop_front()};
    end else begin
      // Filler never looks like a preamble, so idle time stays blanking
      pixel_data_bus_o <= {16'($urandom), (fill_q ? 8'h10 : 8'h80)};
    end
    fill_q <= ~fill_q;
  end
endmodule

// *** verif/video_input_receiver_tb.sv ***
// ============================================================================
// Self-checking bench for the video input receiver
// ============================================================================
module video_input_receiver_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      sys_clk_i = 1'b0;
  logic                      pixel_clk = 1'b0;
  logic                      rst_i     = 1'b1;
  logic [1:0]                lane_cnt  = 2'h0;
  logic                      low_band  = 1'b0;
  logic [3:0]                hs_entry  = 4'h0;
  logic [23:0]               bus;
  video_rx_pkg::pixel_pair_t pair;
  logic                      pair_valid;
  logic                      ovf;
  logic [3:0]                ready;
  int                        bad_count = 0;
  int                        checks    = 0;
  int                        seed;
  video_rx_pkg::pixel_pair_t exp_q[$];

  // Clocks: link clock free-running and unrelated in phase
  always #10 sys_clk_i = ~sys_clk_i;
  initial begin
    #3.7;
    forever #6 pixel_clk = ~pixel_clk;
  end

  video_source_model i_video_source_model (
    .pixel_clk_i      (pixel_clk),
    .pixel_data_bus_o (bus)
  );

  video_input_receiver i_video_input_receiver (
    .sys_clk_i        (sys_clk_i),
    .rst_i            (rst_i),
    .pixel_clk_i      (pixel_clk),
    .pixel_data_bus_i (bus),
    .dsi_lane_count_i (lane_cnt),
    .dsi_low_band_i   (low_band),
    .dsi_hs_entry_i   (hs_entry),
    .pair_o           (pair),
    .pair_valid_o     (pair_valid),
    .overflow_o       (ovf),
    .dsi_lane_ready_o (ready)
  );

  // ==========================================================================
  // Reporting
  // ==========================================================================
  task automatic test_done();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] expv, input logic [63:0] seen);
    checks++;
    if (seen !== expv) begin
      $display("BAD %s expected %h seen %h", what, expv, seen);
      bad_count++;
    end
  endtask

  // Status word with its protection bits worked out
  function automatic logic [7:0] xy(input logic f, input logic v, input logic h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction

  // ==========================================================================
  // Line builder: queues bytes to the source and pairs to expect
  // ==========================================================================
  task automatic send_line(input logic f, input logic v, input int n, input int extra);
    logic [7:0]                b[4];
    video_rx_pkg::pixel_pair_t e;
    i_video_source_model.tx_q.push_back(video_rx_pkg::TRS_PREAMBLE);
    i_video_source_model.tx_q.push_back(video_rx_pkg::TRS_ZERO);
    i_video_source_model.tx_q.push_back(video_rx_pkg::TRS_ZERO);
    i_video_source_model.tx_q.push_back(xy(f, v, 1'b0));
    for (int i = 0; i < n; i++) begin
      foreach (b[k]) begin
        b[k] = 8'($urandom_range(254, 1));
        i_video_source_model.tx_q.push_back(b[k]);
      end
      e = {f, (i == 0), b[0], b[1], b[2], b[3]};
      if (!v) exp_q.push_back(e);
    end
    // A partial group before the end code must be dropped
    for (int i = 0; i < extra; i++) i_video_source_model.tx_q.push_back(8'($urandom_range(254, 1)));
    i_video_source_model.tx_q.push_back(video_rx_pkg::TRS_PREAMBLE);
    i_video_source_model.tx_q.push_back(video_rx_pkg::TRS_ZERO);
    i_video_source_model.tx_q.push_back(video_rx_pkg::TRS_ZERO);
    i_video_source_model.tx_q.push_back(xy(f, v, 1'b1));
    // Status word without its fixed bit: must not open a line
    i_video_source_model.tx_q.push_back(video_rx_pkg::TRS_PREAMBLE);
    i_video_source_model.tx_q.push_back(video_rx_pkg::TRS_ZERO);
    i_video_source_model.tx_q.push_back(video_rx_pkg::TRS_ZERO);
    i_video_source_model.tx_q.push_back(8'h00);
    for (int i = 0; i < 6; i++) i_video_source_model.tx_q.push_back(8'h80);
  endtask

  // Every delivered pair is compared in order with the expectation;
  // sampled mid-cycle, where the registered outputs have settled
  always @(negedge sys_clk_i) begin
    if (!rst_i && pair_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected pair", 64'h0, 64'(pair));
      end else begin
        check("pair", 64'(exp_q.pop_front()), 64'(pair));
      end
      check("overflow", 64'h0, 64'(ovf));
    end
  end

  // ==========================================================================
  // Lane settle: all four lanes enter high speed, lane code n enables 0..n
  // ==========================================================================
  task automatic lane_case(input logic [1:0] n, input logic band, input logic rs);
    int cnt;
    lane_cnt <= n;
    low_band <= band;
    @(posedge sys_clk_i);
    if (rs) begin
      // Aborted entry: the window must restart from the later rise
      hs_entry <= 4'hf;
      repeat (10) @(posedge sys_clk_i);
      hs_entry <= 4'h0;
      repeat (3) @(posedge sys_clk_i);
    end
    hs_entry <= 4'hf;
    cnt = 0;
    do begin
      @(posedge sys_clk_i);
      cnt++;
      #1;
    end while (ready[0] !== 1'b1 && cnt < 60);
    if (cnt >= 60) begin
      bad_count++;
      test_done();
    end
    check("settle cycles", (band ? 64'd28 : 64'd23), 64'(cnt));
    repeat (4) @(posedge sys_clk_i);
    #1;
    check("lane ready mask", 64'((5'h2 << n) - 5'h1), 64'(ready));
    hs_entry <= 4'h0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    check("lane ready off", 64'h0, 64'(ready));
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    int guard;
    seed = $urandom(16);
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    for (int c = 0; c < 8; c++) lane_case(c[1:0], c[2], (c == 7));
    send_line(1'b0, 1'b0, 4, 0);
    send_line(1'b0, 1'b0, 1, 2);
    for (int i = 0; i < 2; i++) send_line(1'b1, 1'b1, 3, 0);
    send_line(1'b1, 1'b0, 6, 3);
    for (int i = 0; i < 6; i++) begin
      send_line(1'($urandom), 1'b0, $urandom_range(8, 1), $urandom_range(3, 0));
    end
    guard = 0;
    while (i_video_source_model.tx_q.size() > 0 && guard < 20000) begin
      @(posedge sys_clk_i);
      guard++;
    end
    if (guard >= 20000) begin
      bad_count++;
      test_done();
    end
    repeat (30) @(posedge sys_clk_i);
    check("pairs left", 64'h0, 64'(exp_q.size()));
    check("overflow end", 64'h0, 64'(ovf));
    test_done();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    bad_count++;
    test_done();
  end
endmodule
